// ---- cfs_can_node.sv ----
// behavioural model of the can nodes that feed received frames
`timescale 1ns/10ps
`default_nettype none
module cfs_can_node (
  // clock
  input wire logic aclk,
  // frame handshake
  input wire logic rx_ready,
  output logic rx_valid,
  output logic rx_port,
  output logic rx_ext,
  output logic [28:0] rx_id,
  output logic [3:0] rx_dlc,
  output logic [63:0] rx_data
);
  initial {rx_valid, rx_port, rx_ext, rx_id, rx_dlc, rx_data} = '0;
  task automatic send(input logic p, input logic e, input logic [28:0] id,
                      input logic [3:0] dlc, input logic [63:0] d);
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_port <= p;
    rx_ext <= e;
    rx_id <= id;
    rx_dlc <= dlc;
    rx_data <= d;
    do @(negedge aclk); while (!rx_ready);
    @(posedge aclk);
    rx_valid <= 1'b0;
    // released id and data lines carry the inverse so a stale frame never looks fresh
    rx_id <= ~id;
    rx_data <= ~d;
  endtask
endmodule
`default_nettype wire

// ---- cfs_fifo.sv ----
// synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module cfs_fifo #(
  parameter int W = 99,
  parameter int D = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp;
  logic [AW:0] rp;
  generate
    if (D < 2 || (1 << AW) != D) begin : g_chk
      $error("fifo depth must be a power of two");
    end
  endgenerate
  assign in_ready = (wp - rp) != (AW+1)'(D);
  assign out_valid = wp != rp;
  assign out_data = mem[rp[AW-1:0]];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp <= '0;
    end else if (in_valid && in_ready) begin
      wp <= wp + 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (in_valid && in_ready) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rp <= '0;
    end else if (out_valid && out_ready) begin
      rp <= rp + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- cfs_map.svh ----
// register map, field positions and reset values of the receive filter and store
`ifndef CFS_MAP_SVH
`define CFS_MAP_SVH
// ***********************
// register offsets
// ***********************
`define CFS_A_CTRL 12'h000
`define CFS_A_STAT 12'h004
`define CFS_A_DROP 12'h008
`define CFS_A_ACPT 12'h00c
`define CFS_R_FLT 3'h1
`define CFS_R_SPC 4'h4
`define CFS_R_RING 3'h4
// ***********************
// fields and values
// ***********************
`define CFS_C_FEN 0
`define CFS_C_SRV 1
`define CFS_C_SAVE 2
`define CFS_F_VLD 0
`define CFS_F_PORT 1
`define CFS_F_EXT 2
`define CFS_F_GRP 3
`define CFS_FLT_LAST 2'h2
`define CFS_STD_MASK 29'h00007ff
`define CFS_EXT_MASK 29'h1fffffff
`define CFS_OKAY 2'h0
`define CFS_SLVERR 2'h2
`define CFS_FEN_RST 1'b0
`define CFS_SRV_RST 1'b0
`endif

// ---- cfs_pkg.sv ----
// types shared by the receive filter and store
package cfs_pkg;
  typedef logic [28:0] cfs_id_t;
  typedef enum logic [1:0] {
    SV_IDLE = 2'b00,
    SV_RUN = 2'b01,
    SV_DONE = 2'b11
  } cfs_save_e;
endpackage

// ---- cfs_rx_asserts.sv ----
// concurrent checks on the receive filter and store ports
`timescale 1ns/10ps
`default_nettype none
module cfs_rx_asserts #(
  parameter int N_FILT = 25
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // nonvolatile store
  input wire logic nvm_valid,
  input wire logic nvm_ready,
  input wire logic [6:0] nvm_addr,
  input wire logic [31:0] nvm_data
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ***********************
  // bus and save walk
  // ***********************
  sequence wr_take;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  endsequence
  sequence nvm_take;
    nvm_valid && nvm_ready;
  endsequence
  wr_answer_a: assert property (wr_take |=> s_axi_bvalid)
    else $error("write answer missing");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  b_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while answering");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  nvm_hold_a: assert property (nvm_valid && !nvm_ready |=> nvm_valid && $stable(nvm_addr) && $stable(nvm_data))
    else $error("save word changed before taken");
  nvm_first_a: assert property ($rose(nvm_valid) |-> nvm_addr == 7'h00)
    else $error("save does not start at entry zero");
  nvm_step_a: assert property (nvm_take ##0 nvm_addr[1:0] != 2'h2 |=> nvm_valid && nvm_addr == $past(nvm_addr) + 7'h01)
    else $error("save word order wrong");
  nvm_wrap_a: assert property (nvm_take ##0 nvm_addr[1:0] == 2'h2 && nvm_addr[6:2] != 5'(N_FILT - 1) |=> nvm_valid && nvm_addr == $past(nvm_addr) + 7'h02)
    else $error("save entry order wrong");
  nvm_end_a: assert property (nvm_take ##0 nvm_addr == {5'(N_FILT - 1), 2'h2} |=> !nvm_valid)
    else $error("save runs past last entry");
endmodule
`default_nettype wire

// ---- cfs_rx_filter.sv ----
// receive acceptance filter, specific identifier slots and ring buffer
`include "cfs_map.svh"
`timescale 1ns/10ps
`default_nettype none
module cfs_rx_filter
  import cfs_pkg::*;
#(
  parameter int N_FILT = 25,
  parameter int N_SPEC = 8,
  parameter int RING_AW = 5,
  parameter int FIFO_D = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // received frames
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic rx_port,
  input wire logic rx_ext,
  input wire logic [28:0] rx_id,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  // nonvolatile store port
  output logic nvm_valid,
  input wire logic nvm_ready,
  output logic [6:0] nvm_addr,
  output logic [31:0] nvm_data,
  // axi4-lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int FW = 99;
  localparam int RD = 1 << RING_AW;
  generate
    if (N_FILT < 1 || N_FILT > 25 || N_SPEC < 1 || N_SPEC > 8) begin : g_chk_tab
      $error("table sizes out of range");
    end
    if (RING_AW < 1 || RING_AW > 5) begin : g_chk_ring
      $error("ring depth out of range");
    end
  endgenerate

  // ***********************
  // state
  // ***********************
  logic filt_en;
  logic srv_mode;
  logic save_req;
  logic save_done;
  logic [31:0] drop_cnt;
  logic [31:0] acpt_cnt;
  logic [N_FILT-1:0] ft_vld;
  logic [N_FILT-1:0] ft_port;
  logic [N_FILT-1:0] ft_ext;
  logic [N_FILT-1:0] ft_grp;
  cfs_id_t ft_lo [N_FILT];
  cfs_id_t ft_hi [N_FILT];
  logic [N_SPEC-1:0] sp_vld;
  logic [N_SPEC-1:0] sp_port;
  logic [N_SPEC-1:0] sp_ext;
  cfs_id_t sp_id [N_SPEC];
  logic [3:0] sp_dlc [N_SPEC];
  logic [63:0] sp_data [N_SPEC];
  logic [7:0] sp_cnt [N_SPEC];
  logic [4:0] rb_meta [RD];
  cfs_id_t rb_id [RD];
  logic [63:0] rb_data [RD];
  logic [RING_AW-1:0] rb_wp;
  logic [5:0] rb_cnt;
  cfs_save_e save_st;
  logic [4:0] sv_ent;
  logic [1:0] sv_wd;

  // ***********************
  // frame fifo and classification
  // ***********************
  logic q_valid;
  logic q_ready;
  logic [FW-1:0] q_frm;
  logic q_port;
  logic q_ext;
  cfs_id_t q_id;
  logic [3:0] q_dlc;
  logic [63:0] q_data;
  logic f_pass;
  logic s_hit;
  logic [2:0] s_idx;
  logic take;
  logic accept;

  cfs_fifo #(.W(FW), .D(FIFO_D)) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data({rx_port, rx_ext, rx_dlc, rx_id, rx_data}),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_frm)
  );
  assign {q_port, q_ext, q_dlc, q_id, q_data} = q_frm;
  // the nvm walk reads the table; frames wait so a save sees one settled view
  assign q_ready = save_st == SV_IDLE;
  assign take = q_valid && q_ready;

  function automatic cfs_id_t id_mask(input logic ext);
    id_mask = ext ? `CFS_EXT_MASK : `CFS_STD_MASK;
  endfunction

  always_comb begin
    cfs_id_t m;
    cfs_id_t lo;
    cfs_id_t hi;
    m = '0;
    lo = '0;
    hi = '0;
    f_pass = 1'b0;
    for (int i = 0; i < N_FILT; i++) begin
      m = q_id & id_mask(ft_ext[i]);
      lo = ft_lo[i] & id_mask(ft_ext[i]);
      hi = ft_grp[i] ? (ft_hi[i] & id_mask(ft_ext[i])) : lo;
      if (ft_vld[i] && ft_port[i] == q_port && ft_ext[i] == q_ext
          && m >= lo && m <= hi) begin
        f_pass = 1'b1;
      end
    end
  end

  always_comb begin
    s_hit = 1'b0;
    s_idx = '0;
    for (int i = N_SPEC - 1; i >= 0; i--) begin
      if (srv_mode && sp_vld[i] && sp_port[i] == q_port && sp_ext[i] == q_ext
          && (q_id & id_mask(q_ext)) == (sp_id[i] & id_mask(q_ext))) begin
        s_hit = 1'b1;
        s_idx = 3'(i);
      end
    end
  end

  assign accept = take && (!filt_en || f_pass);

  // ***********************
  // stores
  // ***********************
  always_ff @(posedge aclk) begin
    if (accept && !s_hit) begin
      rb_meta[rb_wp] <= {q_dlc, q_port};
      rb_id[rb_wp] <= q_id & id_mask(q_ext);
      rb_data[rb_wp] <= q_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rb_wp <= '0;
      rb_cnt <= '0;
    end else if (accept && !s_hit) begin
      rb_wp <= rb_wp + 1'b1;
      if (rb_cnt != 6'(RD)) begin
        rb_cnt <= rb_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (accept && s_hit) begin
      sp_dlc[s_idx] <= q_dlc;
      sp_data[s_idx] <= q_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < N_SPEC; i++) begin
        sp_cnt[i] <= '0;
      end
    end else if (accept && s_hit) begin
      sp_cnt[s_idx] <= sp_cnt[s_idx] + 1'b1;
    end
  end

  // ***********************
  // register read view
  // ***********************
  function automatic logic [32:0] word_at(input logic [11:0] a);
    logic [4:0] fi;
    logic [2:0] si;
    logic [RING_AW-1:0] ri;
    fi = a[8:4];
    si = a[7:5];
    ri = a[RING_AW+3:4];
    word_at = {1'b0, 32'h0};
    if (a[11:2] == `CFS_A_CTRL >> 2) begin
      word_at = {1'b1, 30'h0, srv_mode, filt_en};
    end else if (a[11:2] == `CFS_A_STAT >> 2) begin
      word_at = {1'b1, 14'h0, save_done, save_st != SV_IDLE, 2'h0, rb_cnt, 3'h0,
                 5'(rb_wp)};
    end else if (a[11:2] == `CFS_A_DROP >> 2) begin
      word_at = {1'b1, drop_cnt};
    end else if (a[11:2] == `CFS_A_ACPT >> 2) begin
      word_at = {1'b1, acpt_cnt};
    end else if (a[11:9] == `CFS_R_FLT && 32'(fi) < N_FILT && a[3:2] <= `CFS_FLT_LAST) begin
      case (a[3:2])
        2'h0: word_at = {1'b1, 28'h0, ft_grp[fi], ft_ext[fi], ft_port[fi], ft_vld[fi]};
        2'h1: word_at = {1'b1, 3'h0, ft_lo[fi]};
        default: word_at = {1'b1, 3'h0, ft_hi[fi]};
      endcase
    end else if (a[11:8] == `CFS_R_SPC && 32'(si) < N_SPEC && a[4:2] <= 3'h4) begin
      case (a[4:2])
        3'h0: word_at = {1'b1, 29'h0, sp_ext[si], sp_port[si], sp_vld[si]};
        3'h1: word_at = {1'b1, 3'h0, sp_id[si]};
        3'h2: word_at = {1'b1, 16'h0, sp_cnt[si], 4'h0, sp_dlc[si]};
        3'h3: word_at = {1'b1, sp_data[si][31:0]};
        default: word_at = {1'b1, sp_data[si][63:32]};
      endcase
    end else if (a[11:9] == `CFS_R_RING && 32'(a[8:4]) < RD) begin
      case (a[3:2])
        2'h0: word_at = {1'b1, 3'h0, rb_id[ri]};
        2'h1: word_at = {1'b1, 27'h0, rb_meta[ri]};
        2'h2: word_at = {1'b1, rb_data[ri][31:0]};
        default: word_at = {1'b1, rb_data[ri][63:32]};
      endcase
    end
  endfunction

  // ***********************
  // axi4-lite slave
  // ***********************
  logic aw_go;
  logic [32:0] w_old;
  logic [31:0] wv;
  logic [4:0] w_fi;
  logic [2:0] w_si;

  assign aw_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = aw_go;
  assign s_axi_wready = aw_go;
  assign s_axi_arready = !s_axi_rvalid;
  assign w_old = word_at(s_axi_awaddr);
  assign w_fi = s_axi_awaddr[8:4];
  assign w_si = s_axi_awaddr[7:5];
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wv[b*8 +: 8] = s_axi_wstrb[b] ? s_axi_wdata[b*8 +: 8] : w_old[b*8 +: 8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CFS_OKAY;
    end else if (aw_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= w_old[32] ? `CFS_OKAY : `CFS_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `CFS_OKAY;
      s_axi_rdata <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= word_at(s_axi_araddr) >> 32 != 0 ? `CFS_OKAY : `CFS_SLVERR;
      s_axi_rdata <= 32'(word_at(s_axi_araddr));
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ***********************
  // control and counters
  // ***********************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_en <= `CFS_FEN_RST;
      srv_mode <= `CFS_SRV_RST;
      save_req <= 1'b0;
    end else begin
      save_req <= 1'b0;
      if (aw_go && s_axi_awaddr[11:2] == `CFS_A_CTRL >> 2) begin
        filt_en <= wv[`CFS_C_FEN];
        srv_mode <= wv[`CFS_C_SRV];
        save_req <= wv[`CFS_C_SAVE];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drop_cnt <= '0;
    end else if (take && !accept) begin
      drop_cnt <= (aw_go && s_axi_awaddr[11:2] == `CFS_A_DROP >> 2) ? 32'h1 : drop_cnt + 1'b1;
    end else if (aw_go && s_axi_awaddr[11:2] == `CFS_A_DROP >> 2) begin
      drop_cnt <= '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acpt_cnt <= '0;
    end else if (accept) begin
      acpt_cnt <= (aw_go && s_axi_awaddr[11:2] == `CFS_A_ACPT >> 2) ? 32'h1 : acpt_cnt + 1'b1;
    end else if (aw_go && s_axi_awaddr[11:2] == `CFS_A_ACPT >> 2) begin
      acpt_cnt <= '0;
    end
  end

  // ***********************
  // table writes
  // ***********************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ft_vld <= '0;
    end else if (aw_go && s_axi_awaddr[11:9] == `CFS_R_FLT && w_old[32]) begin
      case (s_axi_awaddr[3:2])
        2'h0: begin
          ft_vld[w_fi] <= wv[`CFS_F_VLD];
          ft_port[w_fi] <= wv[`CFS_F_PORT];
          ft_ext[w_fi] <= wv[`CFS_F_EXT];
          ft_grp[w_fi] <= wv[`CFS_F_GRP];
        end
        2'h1: ft_lo[w_fi] <= wv[28:0];
        default: ft_hi[w_fi] <= wv[28:0];
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_vld <= '0;
    end else if (aw_go && s_axi_awaddr[11:8] == `CFS_R_SPC && w_old[32]) begin
      case (s_axi_awaddr[4:2])
        3'h0: begin
          sp_vld[w_si] <= wv[`CFS_F_VLD];
          sp_port[w_si] <= wv[`CFS_F_PORT];
          sp_ext[w_si] <= wv[`CFS_F_EXT];
        end
        3'h1: sp_id[w_si] <= wv[28:0];
        default: ;
      endcase
    end
  end

  // ***********************
  // save walk to nvm
  // ***********************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      save_st <= SV_IDLE;
      save_done <= 1'b0;
      sv_ent <= '0;
      sv_wd <= '0;
      nvm_valid <= 1'b0;
      nvm_addr <= '0;
      nvm_data <= '0;
    end else begin
      case (save_st)
        SV_IDLE: begin
          if (save_req) begin
            save_st <= SV_RUN;
            save_done <= 1'b0;
            sv_ent <= '0;
            sv_wd <= '0;
            nvm_valid <= 1'b1;
            nvm_addr <= '0;
            nvm_data <= 32'(word_at({`CFS_R_FLT, 9'h0}));
          end
        end
        SV_RUN: begin
          if (nvm_ready) begin
            if (sv_wd == `CFS_FLT_LAST && 32'(sv_ent) == N_FILT - 1) begin
              nvm_valid <= 1'b0;
              save_st <= SV_DONE;
            end else if (sv_wd == `CFS_FLT_LAST) begin
              sv_ent <= sv_ent + 1'b1;
              sv_wd <= '0;
              nvm_addr <= {sv_ent + 1'b1, 2'h0};
              nvm_data <= 32'(word_at({`CFS_R_FLT, sv_ent + 1'b1, 4'h0}));
            end else begin
              sv_wd <= sv_wd + 1'b1;
              nvm_addr <= {sv_ent, sv_wd + 1'b1};
              nvm_data <= 32'(word_at({`CFS_R_FLT, sv_ent, sv_wd + 1'b1, 2'h0}));
            end
          end
        end
        SV_DONE: begin
          save_done <= 1'b1;
          save_st <= SV_IDLE;
        end
        default: save_st <= SV_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- tb_can_rx_id_filter_and_store.sv ----
// self-checking bench of the receive filter and store
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_can_rx_id_filter_and_store;
  logic aclk = 0;
  logic aresetn = 0;
  logic rxv, rxr, rxp, rxe, nv, awr, wrr, bv, arr, rv;
  logic nr = 0, hold = 1, wrv = 0, br = 0, arv = 0, rr = 0;
  logic [28:0] rxid;
  logic [3:0] rxdlc;
  logic [63:0] rxd;
  logic [6:0] na;
  logic [31:0] nd, nlo, rdat, v, wd = 0;
  logic [11:0] awa = 0, ara = 0, a;
  logic [1:0] bresp, rresp, resp;
  logic [4:0] ptr;
  int fails = 0, checked = 0, cyc = 0, taken = 0, nw = 0, ea = 0, ed = 0, t0;
  integer seed = 32'ha3c3;
  logic [3:0] fc [3] = '{4'h1, 4'hb, 4'hd};
  logic [28:0] flo [3] = '{29'h123, 29'h1, 29'h456};
  logic [28:0] fhi [3] = '{29'h123, 29'h3, 29'h789};
  logic [28:0] cor [10] = '{29'h123, 29'h124, 29'h0, 29'h1, 29'h3, 29'h4, 29'h455,
                            29'h456, 29'h789, 29'h78a};
  cfs_rx_filter DUT (
    .aclk(aclk), .aresetn(aresetn), .rx_valid(rxv), .rx_ready(rxr), .rx_port(rxp),
    .rx_ext(rxe), .rx_id(rxid), .rx_dlc(rxdlc), .rx_data(rxd), .nvm_valid(nv),
    .nvm_ready(nr), .nvm_addr(na), .nvm_data(nd), .s_axi_awaddr(awa), .s_axi_awvalid(wrv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wrv),
    .s_axi_wready(wrr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
  cfs_can_node node (.aclk(aclk), .rx_ready(rxr), .rx_valid(rxv), .rx_port(rxp),
    .rx_ext(rxe), .rx_id(rxid), .rx_dlc(rxdlc), .rx_data(rxd));
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    nr <= !hold && ($random(seed) % 2 != 0);
    if (rxv && rxr) taken <= taken + 1;
    if (nv && nr) nw <= nw + 1;
    if (nv && nr && na == 7'h05) nlo <= nd;
    if (cyc == 30000) begin
      fails++;
      print_verdict;
    end
  end
  // ***********************
  // bus tasks and expectations
  // ***********************
  task wr(input logic [11:0] ad, input logic [31:0] d);
    @(posedge aclk);
    awa <= ad;
    wd <= d;
    wrv <= 1'b1;
    br <= 1'b1;
    do @(negedge aclk); while (!(awr && wrr));
    @(posedge aclk);
    wrv <= 1'b0;
    do @(negedge aclk); while (!bv);
    @(posedge aclk);
    br <= 1'b0;
  endtask
  task rd(input logic [11:0] ad);
    @(posedge aclk);
    ara <= ad;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(negedge aclk); while (!arr);
    @(posedge aclk);
    arv <= 1'b0;
    do @(negedge aclk); while (!rv);
    v = rdat;
    resp = rresp;
    @(posedge aclk);
    rr <= 1'b0;
  endtask
  task rchk(input logic [11:0] ad, input logic [31:0] e, input string n);
    rd(ad);
    `CHK(n, e, v)
  endtask
  function automatic logic pass(input logic p, input logic e, input logic [28:0] id);
    logic [28:0] m;
    pass = 0;
    m = e ? id : id & 29'h7ff;
    for (int i = 0; i < 3; i++) begin
      if (fc[i][0] && fc[i][1] == p && fc[i][2] == e && m >= flo[i] &&
          m <= (fc[i][3] ? fhi[i] : flo[i])) pass = 1;
    end
  endfunction
  task burst(input int n);
    logic [28:0] id;
    for (int i = 0; i < n; i++) begin
      v = $random(seed);
      id = cor[v[5:2] % 10];
      if (!v[1]) id[28:11] = v[31:14];
      if (pass(v[0], v[1], id)) ea++;
      else ed++;
      node.send(v[0], v[1], id, 4'h8, {$random(seed), $random(seed)});
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    node.send(1'b1, 1'b1, 29'h1abcdef, 4'h5, 64'h0123456789abcdef);
    rchk(12'h00c, 32'h1, "accept all");
    rchk(12'h800, 32'h1abcdef, "ring id");
    rchk(12'h804, 32'hb, "ring meta");
    rchk(12'h808, 32'h89abcdef, "ring data");
    rchk(12'h100, 32'h0, "unmapped");
    `CHK("unmapped resp", 2'h2, resp)
    $display("test filter_off done");
    for (int i = 0; i < 3; i++) begin
      a = 12'h200 + 12'(16 * i);
      wr(a, {28'h0, fc[i]});
      wr(a + 12'h4, {3'h0, flo[i]});
      wr(a + 12'h8, {3'h0, fhi[i]});
    end
    wr(12'h008, 32'h0);
    wr(12'h00c, 32'h0);
    wr(12'h000, 32'h1);
    burst(40);
    rchk(12'h008, ed, "drop count");
    rchk(12'h00c, ea, "accept count");
    wr(12'h200, 32'h0);
    fc[0] = 4'h0;
    burst(20);
    rchk(12'h008, ed, "drop after remove");
    $display("test filter_table done");
    wr(12'h400, 32'h3);
    wr(12'h404, 32'h2);
    rd(12'h004);
    ptr = v[4:0];
    node.send(1'b1, 1'b0, 29'h2, 4'h8, 64'h1);
    rd(12'h004);
    `CHK("server off ptr", ptr + 5'h1, v[4:0])
    wr(12'h000, 32'h3);
    node.send(1'b1, 1'b0, 29'h2, 4'h8, 64'h11);
    node.send(1'b1, 1'b0, 29'h1ffff802, 4'h8, 64'h22);
    rchk(12'h408, 32'h208, "slot count");
    rchk(12'h40c, 32'h22, "slot data");
    rd(12'h004);
    `CHK("slot ptr", ptr + 5'h1, v[4:0])
    wr(12'h000, 32'h2);
    node.send(1'b0, 1'b0, 29'h2, 4'h8, 64'h33);
    node.send(1'b1, 1'b1, 29'h2, 4'h8, 64'h44);
    rchk(12'h408, 32'h208, "slot other");
    rd(12'h004);
    `CHK("other ptr", ptr + 5'h3, v[4:0])
    $display("test specific done");
    wr(12'h00c, 32'h0);
    wr(12'h000, 32'h4);
    t0 = taken;
    fork
      repeat (17) node.send(1'b0, 1'b0, 29'h5, 4'h1, 64'h0);
    join_none
    repeat (60) @(posedge aclk);
    `CHK("fifo fill", 16, taken - t0)
    `CHK("fifo refuse", 1'b0, rxr)
    // ring fill: first frame, every burst accept, three ring frames of the specific test
    rchk(12'h004, {ptr + 5'h3} | (32'((ea > 28) ? 32 : ea + 4) << 8) | 32'h10000,
         "save busy");
    hold <= 1'b0;
    wait fork;
    do rd(12'h004); while (!v[17]);
    `CHK("save words", 75, nw)
    `CHK("save entry lo", 32'h1, nlo)
    // let the queued frames drain before counting them
    repeat (24) @(posedge aclk);
    rchk(12'h00c, 32'd17, "drained");
    $display("test save done");
    print_verdict;
  end
endmodule
bind cfs_rx_filter cfs_rx_asserts #(.N_FILT(N_FILT)) u_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .nvm_valid, .nvm_ready, .nvm_addr, .nvm_data);
`default_nettype wire
